// >>> hw/dps_params.svh
// Shared constants of the dual pot serial register logic
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH
// Device type code; value is arbitrary
`define DPS_TYPE_CODE  4'hA
// Opcodes, upper nibble of the instruction byte
`define DPS_OP_RD_WCR  4'h9
`define DPS_OP_WR_WCR  4'hA
`define DPS_OP_RD_DR   4'hB
`define DPS_OP_WR_DR   4'hC
`define DPS_OP_DR2W    4'hD
`define DPS_OP_W2DR    4'hE
`define DPS_OP_G_DR2W  4'h1
`define DPS_OP_G_W2DR  4'h8
`define DPS_OP_STEP    4'h2
`define DPS_OP_RD_SR   4'h5
// Field positions in the instruction byte
`define DPS_OP_LSB     4
`define DPS_BANK_LSB   2
`define DPS_POT_BIT    0
// Reset contents and wiper limits
`define DPS_STORE_RST  8'h80
`define DPS_WIPER_LO   8'h00
`define DPS_WIPER_HI   8'hFF
`define DPS_TAPS       256
// Nonvolatile write time and its cycle count
`define DPS_NV_MS      10
`define DPS_CLK_MHZ    125
`define DPS_NV_CYC     (`DPS_NV_MS * 1000 * `DPS_CLK_MHZ)
`endif

// >>> hw/dps_pkg.sv
// Types of the dual pot serial register logic
`default_nettype none
package dps_pkg;
  // Link frame states, one-hot
  typedef enum logic [5:0] {
    DPS_ST_ID   = 6'h01, // Identity byte
    DPS_ST_INS  = 6'h02, // Instruction byte
    DPS_ST_RX   = 6'h04, // Data byte in
    DPS_ST_TX   = 6'h08, // Data byte out
    DPS_ST_STEP = 6'h10, // Wiper stepping
    DPS_ST_MUTE = 6'h20  // Silent until deselect
  } dps_link_st_t;
endpackage
`default_nettype wire

// >>> hw/dps_link.sv
// Serial front end of the dual pot, on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "dps_params.svh"
module dps_link
  import dps_pkg::*;
(
  input  wire logic        sck,        // Link clock
  input  wire logic        rst_n,      // Reset, low, async here
  input  wire logic        cs_n,       // Select, low
  input  wire logic        hold_n,     // Pause, low
  input  wire logic        si,         // Serial in
  input  wire logic [7:0]  snap_w0,    // Frozen wiper 0
  input  wire logic [7:0]  snap_w1,    // Frozen wiper 1
  input  wire logic [63:0] snap_dr,    // Frozen stored settings
  input  wire logic        snap_wip,   // Frozen write flag
  input  wire logic [1:0]  snap_strap, // Synchronised straps, not frozen
  output logic [3:0]       cmd_op,     // Command opcode
  output logic [1:0]       cmd_bank,   // Command bank
  output logic             cmd_pot,    // Command pot
  output logic [7:0]       cmd_data,   // Command data
  output logic             cmd_dir,    // Step direction
  output logic             cmd_tgl,    // Toggles per command
  output logic             so_o,       // Serial out
  output logic             so_oe       // Serial out enable
);
  dps_link_st_t state_r;   // Frame state
  dps_link_st_t state_nxt; // Next frame state
  logic [2:0]   cnt_r;     // Bit within byte
  logic [6:0]   sh_r;      // Bits so far
  logic [7:0]   ins_r;     // Held instruction
  logic [7:0]   tx_r;      // Outgoing byte
  wire          link_clr;  // Frame clear
  wire  [7:0]   byte_w;    // Byte incl. current bit
  wire  [3:0]   op_w;      // Opcode field
  wire  [2:0]   slot_w;    // Pot and bank
  wire  [7:0]   rd_sel;    // Data to return
  wire  [7:0]   ins_src;   // Instruction source
  wire          byte_end, id_ok, in_ins, fire;
  wire          is_rd, is_wr, is_step, is_xfr;

  // Deselect clears the frame; the clock stops outside frames
  assign link_clr = cs_n | ~rst_n;
  assign byte_w   = {sh_r, si};
  assign byte_end = (cnt_r == 3'h7);
  assign op_w     = byte_w[`DPS_OP_LSB +: 4];
  assign slot_w   = {byte_w[`DPS_POT_BIT], byte_w[`DPS_BANK_LSB +: 2]};
  // Type code and both strap bits must match
  assign id_ok = (op_w == `DPS_TYPE_CODE) && (byte_w[3:2] == 2'h0)
              && (byte_w[1:0] == snap_strap);
  // Opcode classes
  assign is_rd = (op_w == `DPS_OP_RD_WCR) || (op_w == `DPS_OP_RD_DR)
              || (op_w == `DPS_OP_RD_SR);
  assign is_wr = (op_w == `DPS_OP_WR_WCR) || (op_w == `DPS_OP_WR_DR);
  assign is_step = (op_w == `DPS_OP_STEP);
  assign is_xfr = (op_w == `DPS_OP_DR2W) || (op_w == `DPS_OP_W2DR)
               || (op_w == `DPS_OP_G_DR2W) || (op_w == `DPS_OP_G_W2DR);
  // Read source picked by the instruction byte
  assign rd_sel = (op_w == `DPS_OP_RD_WCR) ? (slot_w[2] ? snap_w1 : snap_w0)
                : (op_w == `DPS_OP_RD_DR) ? snap_dr[{slot_w, 3'h0} +: 8]
                : {7'h00, snap_wip};
  assign in_ins  = (state_r == DPS_ST_INS);
  assign ins_src = in_ins ? byte_w : ins_r;
  // Command issue points; stepping fires on every unpaused edge
  assign fire = hold_n && ((in_ins && byte_end && is_xfr)
             || (state_r == DPS_ST_RX && byte_end)
             || (state_r == DPS_ST_STEP));

  // Frame sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DPS_ST_ID: begin
        if (byte_end) state_nxt = id_ok ? DPS_ST_INS : DPS_ST_MUTE;
      end
      DPS_ST_INS: begin
        if (byte_end) begin
          state_nxt = is_rd ? DPS_ST_TX : is_wr ? DPS_ST_RX
                    : is_step ? DPS_ST_STEP : DPS_ST_MUTE;
        end
      end
      DPS_ST_RX, DPS_ST_TX: begin
        if (byte_end) state_nxt = DPS_ST_MUTE;
      end
      DPS_ST_STEP, DPS_ST_MUTE: state_nxt = state_r;
    endcase
  end

  // Shift on the rising edge; a pause freezes everything
  always_ff @(posedge sck or posedge link_clr) begin
    if (link_clr) begin
      state_r <= DPS_ST_ID;
      cnt_r   <= 3'h0;
      sh_r    <= 7'h00;
      ins_r   <= 8'h00;
      tx_r    <= 8'h00;
    end else if (hold_n) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_r + 3'h1;
      sh_r    <= byte_w[6:0];
      if (in_ins && byte_end) begin
        ins_r <= byte_w;
        tx_r  <= rd_sel;
      end else if (state_r == DPS_ST_TX) begin
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // Command word; held until the next command, so it crosses stable
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      cmd_op   <= 4'h0;
      cmd_bank <= 2'h0;
      cmd_pot  <= 1'b0;
      cmd_data <= 8'h00;
      cmd_dir  <= 1'b0;
      cmd_tgl  <= 1'b0;
    end else if (fire) begin
      cmd_op   <= ins_src[`DPS_OP_LSB +: 4];
      cmd_bank <= ins_src[`DPS_BANK_LSB +: 2];
      cmd_pot  <= ins_src[`DPS_POT_BIT];
      cmd_data <= byte_w;
      cmd_dir  <= si;
      cmd_tgl  <= ~cmd_tgl;
    end
  end

  // Output changes on the falling edge, driven only while returning data
  always_ff @(negedge sck or posedge link_clr) begin
    if (link_clr) begin
      so_o  <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so_o  <= tx_r[7];
      so_oe <= (state_r == DPS_ST_TX) && hold_n;
    end
  end

  a_id_miss: assert property (@(posedge sck) disable iff (link_clr)
    (state_r == DPS_ST_ID) && byte_end && hold_n && !id_ok
    |=> (state_r == DPS_ST_MUTE) ##1 (state_r == DPS_ST_MUTE))
    else $error("identity miss did not mute");
  a_mute_quiet: assert property (@(posedge sck) disable iff (link_clr)
    (state_r == DPS_ST_MUTE) |-> !so_oe)
    else $error("serial out driven while muted");
  a_pause_freeze: assert property (@(posedge sck) disable iff (link_clr)
    !hold_n |=> $stable(cnt_r) && $stable(state_r) && $stable(sh_r))
    else $error("frame moved during pause");
  a_rise_sample: assert property (@(posedge sck) disable iff (link_clr)
    ((state_r == DPS_ST_STEP) || ((state_r == DPS_ST_RX) && byte_end)) && hold_n
    |=> cmd_data[0] == $past(si))
    else $error("last data bit not taken on rising edge");
  c_read_frame: cover property (@(posedge sck) disable iff (link_clr)
    (state_r == DPS_ST_TX) && byte_end);
endmodule
`default_nettype wire

// >>> hw/dps_top.sv
// Dual pot serial register logic: registers, crossing and tap decode
`timescale 1ns/1ps
`default_nettype none
`include "dps_params.svh"
module dps_top
  import dps_pkg::*;
#(
  parameter int unsigned NV_WRITE_CYC = `DPS_NV_CYC // Nv write length, cycles
)(
  input  wire logic              CLK,         // System clock
  input  wire logic              RST_N,       // Sync reset, low
  input  wire logic              SCK,         // Link clock
  input  wire logic              CS_N,        // Select, low
  input  wire logic              PAUSE_N,     // Pause, low
  input  wire logic              SI,          // Serial in
  input  wire logic              NVW_GUARD_N, // Low blocks nv writes
  input  wire logic              STRAP_HI,    // Address strap, upper
  input  wire logic              STRAP_LO,    // Address strap, lower
  output logic                   SO_O,        // Serial out
  output logic                   SO_OE,       // Serial out enable
  output logic [`DPS_TAPS-1:0]   TAP_0,       // Pot 0 tap switches
  output logic [`DPS_TAPS-1:0]   TAP_1,       // Pot 1 tap switches
  output logic                   WIP,         // Write in progress
  output logic                   STANDBY      // Standby state
);
  localparam int NV_CW = $clog2(NV_WRITE_CYC + 1); // Timer width

  // Synchronisers, first stage read only by second
  logic             cs_m_r, cs_s_r, cs_d_r;    // Select
  logic             wp_m_r, wp_s_r;            // Guard
  logic [1:0]       st_m_r, st_s_r;            // Straps
  logic             tgl_m_r, tgl_s_r, tgl_d_r; // Command toggle
  // Control state
  logic             armed_r;   // Select fall seen
  logic             boot_r;    // Power-up load pending
  logic             wip_r;     // Write in progress
  logic [NV_CW-1:0] nv_cnt_r;  // Write timer
  logic             standby_r; // Standby output
  logic [1:0]       warm_r;    // Edges since reset, saturating
  // Snapshot handed to the link, frozen while selected except the straps
  logic [7:0]       snap_w0_r, snap_w1_r;
  logic [63:0]      snap_dr_r;
  logic             snap_wip_r;
  logic [1:0]       snap_st_r;
  // Link command word
  wire  [3:0]       cmd_op;
  wire  [1:0]       cmd_bank;
  wire  [7:0]       cmd_data;
  wire              cmd_pot, cmd_dir, cmd_tgl;
  // Register views
  wire  [1:0][7:0]  pos_w;    // Wiper positions
  wire  [7:0][7:0]  store_w;  // Stored settings by {pot,bank}
  wire  [1:0][`DPS_TAPS-1:0] tap_w; // Tap selections
  // Command decode
  wire              fire, nv_op, nv_go;
  wire              cs_fall;   // Select fall from real samples only
  wire              op_wrw, op_d2w, op_gd2w, op_step;
  wire              op_wrd, op_w2d, op_gw2d;

  // Pin synchronisers for select, guard and straps
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
      wp_m_r <= 1'b0;
      wp_s_r <= 1'b0;
      st_m_r <= 2'h0;
      st_s_r <= 2'h0;
    end else begin
      cs_m_r <= CS_N;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
      wp_m_r <= NVW_GUARD_N;
      wp_s_r <= wp_m_r;
      st_m_r <= {STRAP_HI, STRAP_LO};
      st_s_r <= st_m_r;
    end
  end

  // Command toggle crossing; data is stable by the time it is seen
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tgl_m_r <= 1'b0;
      tgl_s_r <= 1'b0;
      tgl_d_r <= 1'b0;
    end else begin
      tgl_m_r <= cmd_tgl;
      tgl_s_r <= tgl_m_r;
      tgl_d_r <= tgl_s_r;
    end
  end

  // Serial front end on the link clock
  dps_link u_link (
    .sck        (SCK),
    .rst_n      (RST_N),
    .cs_n       (CS_N),
    .hold_n     (PAUSE_N),
    .si         (SI),
    .snap_w0    (snap_w0_r),
    .snap_w1    (snap_w1_r),
    .snap_dr    (snap_dr_r),
    .snap_wip   (snap_wip_r),
    .snap_strap (snap_st_r),
    .cmd_op     (cmd_op),
    .cmd_bank   (cmd_bank),
    .cmd_pot    (cmd_pot),
    .cmd_data   (cmd_data),
    .cmd_dir    (cmd_dir),
    .cmd_tgl    (cmd_tgl),
    .so_o       (SO_O),
    .so_oe      (SO_OE)
  );

  // Commands count only once a select fall has been seen
  assign fire    = armed_r && (tgl_s_r ^ tgl_d_r);
  assign op_wrw  = (cmd_op == `DPS_OP_WR_WCR);
  assign op_d2w  = (cmd_op == `DPS_OP_DR2W);
  assign op_gd2w = (cmd_op == `DPS_OP_G_DR2W);
  assign op_step = (cmd_op == `DPS_OP_STEP);
  assign op_wrd  = (cmd_op == `DPS_OP_WR_DR);
  assign op_w2d  = (cmd_op == `DPS_OP_W2DR);
  assign op_gw2d = (cmd_op == `DPS_OP_G_W2DR);
  assign nv_op   = fire && (op_wrd || op_w2d || op_gw2d);
  // Writes during a running cycle are dropped, not queued
  assign nv_go   = nv_op && wp_s_r && !wip_r;
  // Chain resets to deselected; a pin low at release is not a fall
  assign cs_fall = (warm_r == 2'h3) && cs_d_r && !cs_s_r;

  // Arm on select fall, one-shot boot load, standby
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      armed_r   <= 1'b0;
      boot_r    <= 1'b1;
      standby_r <= 1'b1;
      warm_r    <= 2'h0;
    end else begin
      armed_r   <= armed_r | cs_fall;
      boot_r    <= 1'b0;
      standby_r <= cs_s_r && !wip_r;
      warm_r    <= warm_r + {1'b0, (warm_r != 2'h3)};
    end
  end

  // Nonvolatile write timer
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wip_r    <= 1'b0;
      nv_cnt_r <= '0;
    end else if (nv_go) begin
      wip_r    <= 1'b1;
      nv_cnt_r <= NV_CW'(NV_WRITE_CYC);
    end else if (wip_r) begin
      nv_cnt_r <= nv_cnt_r - NV_CW'(1);
      if (nv_cnt_r == NV_CW'(1)) wip_r <= 1'b0;
    end
  end

  // Per-pot wiper and tap decode
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pot
      localparam logic PB = 1'(p);
      logic [7:0]           pos_r;  // Wiper position
      logic [7:0]           pos_nxt;
      logic [7:0]           step_v; // Stepped, saturating
      logic [`DPS_TAPS-1:0] tap_r;  // One-hot switches
      wire                  sel = (cmd_pot == PB);
      assign step_v = cmd_dir
        ? ((pos_r == `DPS_WIPER_HI) ? pos_r : pos_r + 8'h01)
        : ((pos_r == `DPS_WIPER_LO) ? pos_r : pos_r - 8'h01);
      // Four sources only; boot load wins
      assign pos_nxt = boot_r ? store_w[{PB, 2'h0}]
        : (fire && op_wrw && sel) ? cmd_data
        : (fire && ((op_d2w && sel) || op_gd2w)) ? store_w[{PB, cmd_bank}]
        : (fire && op_step && sel) ? step_v
        : pos_r;
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          pos_r <= `DPS_WIPER_LO;
          tap_r <= 256'h1;
        end else begin
          pos_r <= pos_nxt;
          tap_r <= 256'h1 << pos_r;
        end
      end
      assign pos_w[p] = pos_r;
      assign tap_w[p] = tap_r;
    end
  endgenerate

  // Stored settings, one per {pot,bank}
  genvar e;
  generate
    for (e = 0; e < 8; e++) begin : g_slot
      localparam logic [2:0] SL = 3'(e);
      logic [7:0] val_r; // Stored setting
      wire        hit = (cmd_bank == SL[1:0])
                     && (op_gw2d || (cmd_pot == SL[2]));
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          val_r <= `DPS_STORE_RST;
        end else if (nv_go && hit) begin
          val_r <= op_wrd ? cmd_data : pos_w[SL[2]];
        end
      end
      assign store_w[e] = val_r;
    end
  endgenerate

  // Snapshot updates only while deselected, so the link reads it quiet
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      snap_w0_r  <= 8'h00;
      snap_w1_r  <= 8'h00;
      snap_dr_r  <= 64'h0;
      snap_wip_r <= 1'b0;
    end else if (cs_s_r) begin
      snap_w0_r  <= pos_w[0];
      snap_w1_r  <= pos_w[1];
      snap_dr_r  <= store_w;
      snap_wip_r <= wip_r;
    end
  end

  // Straps are static, so they need no select gate
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      snap_st_r <= 2'h0;
    end else begin
      snap_st_r <= st_s_r;
    end
  end

  assign TAP_0   = tap_w[0];
  assign TAP_1   = tap_w[1];
  assign WIP     = wip_r;
  assign STANDBY = standby_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_guard_block: assert property (
    nv_op && !wp_s_r |=> $stable(store_w) && !$rose(wip_r))
    else $error("nv write passed a low guard");
  a_arm_gate: assert property (
    !armed_r && (tgl_s_r ^ tgl_d_r) && !boot_r |=> $stable(pos_w) && $stable(store_w))
    else $error("command acted before select fall");
  a_wip_start: assert property (
    $rose(wip_r) |-> $past(nv_go))
    else $error("write flag rose without a write");
  a_wip_bound: assert property (
    wip_r |-> (nv_cnt_r != '0) && (nv_cnt_r <= NV_CW'(NV_WRITE_CYC)))
    else $error("write timer out of range");
  a_wip_clear: assert property (
    wip_r && (nv_cnt_r == NV_CW'(1)) |=> !wip_r ##1 !WIP)
    else $error("write flag did not clear");
  a_boot_load: assert property (
    boot_r |=> (pos_w[0] == $past(store_w[0])) && (pos_w[1] == $past(store_w[4])))
    else $error("power-up load missed");
  a_tap_onehot: assert property (
    ##1 $onehot(TAP_0) && $onehot(TAP_1) && TAP_0[$past(pos_w[0])] && TAP_1[$past(pos_w[1])])
    else $error("tap select not one-hot");
  a_tap_ends: assert property (
    (pos_w[0] == `DPS_WIPER_HI) && $stable(pos_w[0]) |=> TAP_0[`DPS_TAPS-1])
    else $error("full scale not at high end");
  a_step_up: assert property (
    fire && op_step && cmd_dir && !cmd_pot && !boot_r && (pos_w[0] != `DPS_WIPER_HI)
    |=> pos_w[0] == $past(pos_w[0]) + 8'h01)
    else $error("step up did not move one segment");
  a_standby: assert property (
    !cs_s_r |=> !STANDBY)
    else $error("standby while selected");

  c_nv_write: cover property (nv_go ##[1:20] wip_r);
  c_step: cover property (fire && op_step);
  c_global: cover property (fire && op_gd2w);
  c_wip_done: cover property ($fell(wip_r));
endmodule
`default_nettype wire

// >>> dv/dps_mst.sv
// Serial bus master model that drives the dual pot link
`timescale 1ns/1ps
`default_nettype none
module dps_mst (
  output logic      sck,     // Link clock, still between frames
  output logic      cs_n,    // Select, low
  output logic      pause_n, // Pause, low
  output logic      si,      // Data to the device
  input  wire logic so_o,    // Data from the device
  input  wire logic so_oe    // Device drives so_o
);
  localparam int HP = 24;    // Half of the 48 ns link period
  logic [7:0] rd;            // Third byte as read back
  logic       oe_seen;       // Device drove its output
  // Idle: clock low, deselected, no pause
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    pause_n = 1'b1;
    si = 1'b0;
    rd = 8'h00;
    oe_seen = 1'b0;
  end
  // Select; the device arms on this fall
  task automatic sel;
    oe_seen = 1'b0;
    #(HP) cs_n = 1'b0;
    #(HP);
  endtask
  // Shift n bits MSB first, select held low throughout
  task automatic shift(input logic [23:0] d, input int n, input int p);
    for (int i = 0; i < n; i++) begin
      if (i == p) begin
        #4 pause_n = 1'b0;   // Freeze with clock low
        repeat (3) begin
          si = ~si;          // Noise the paused device must ignore
          #(HP) sck = 1'b1;
          #(HP) sck = 1'b0;
        end
        #4 pause_n = 1'b1;   // Resume with clock low
      end
      si = d[23-i];          // Set up while clock is low
      #(HP) sck = 1'b1;
      if (i >= 16) begin
        rd = {rd[6:0], so_oe ? so_o : 1'bx};  // Undriven bit reads unknown
      end
      oe_seen = oe_seen | so_oe;
      #(HP) sck = 1'b0;
    end
  endtask
  // End the frame; the freed line shows no stale level
  task automatic desel;
    #(HP) cs_n = 1'b1;
    si = ~si;
    #120;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the dual pot register logic
`timescale 1ns/1ps
`default_nettype none
`include "dps_params.svh"
module tb_top;
  localparam int NV = 400;             // Short nonvolatile write
  logic                 clk = 1'b0;     // System clock
  logic                 rst_n = 1'b0;   // Reset, low
  logic                 guard_n = 1'b1; // Nv write guard
  logic                 st_hi = 1'b1;   // Upper strap
  logic                 st_lo = 1'b0;   // Lower strap
  logic                 sck, cs_n, pause_n, si, so_o, so_oe; // Link pins
  logic [`DPS_TAPS-1:0] tap0, tap1;     // Tap selects
  logic                 wip, stby;      // Status outputs
  logic [7:0]           id;             // Matching identity byte
  int                   fails = 0;      // Mismatches
  int                   tests_run = 0;  // Comparisons
  int                   cnt;            // Measured write length
  assign id = {`DPS_TYPE_CODE, 2'b00, st_hi, st_lo};
  // 125 MHz system clock
  always #4 clk = ~clk;
  dps_top #(.NV_WRITE_CYC(NV)) i_dut (
    .CLK(clk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n), .PAUSE_N(pause_n), .SI(si),
    .NVW_GUARD_N(guard_n), .STRAP_HI(st_hi), .STRAP_LO(st_lo), .SO_O(so_o),
    .SO_OE(so_oe), .TAP_0(tap0), .TAP_1(tap1), .WIP(wip), .STANDBY(stby)
  );
  dps_mst i_mst (
    .sck(sck), .cs_n(cs_n), .pause_n(pause_n), .si(si), .so_o(so_o), .so_oe(so_oe)
  );
  // Instruction byte from its fields
  function automatic logic [7:0] ins(input logic [3:0] op, input logic [1:0] b,
                                     input logic p);
    return {op, b, 1'b0, p};
  endfunction
  // One-hot tap expected for a wiper value
  function automatic logic [255:0] oh(input logic [7:0] v);
    return 256'h1 << v;
  endfunction
  // Compare and count
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Let edges land, then sample
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One whole frame
  task automatic frm(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                     input int n, input int p);
    i_mst.sel;
    i_mst.shift({a, b, c}, n, p);
    i_mst.desel;
  endtask
  // Bounded wait for the write to finish
  task automatic wait_wip;
    for (int k = 0; k <= 1000; k++) begin
      tick(1);
      if (wip === 1'b0) return;
    end
    fails++;
    $display("ERROR %0t: write flag stuck", $time);
    end_of_test;
  endtask
  // Power-up load, then a frame with no select fall after reset
  task automatic t_boot;
    i_mst.sel;
    @(posedge clk) rst_n <= 1'b1;
    tick(3);
    chk(tap0, oh(8'h80));
    chk(tap1, oh(8'h80));
    chk(wip, 1'b0);
    repeat (6) @(posedge clk);
    i_mst.shift({id, ins(`DPS_OP_WR_WCR, 2'b00, 1'b0), 8'h11}, 24, 99);
    i_mst.desel;
    chk(tap0, oh(8'h80));
    chk(stby, 1'b1);
    chk(so_oe, 1'b0);
  endtask
  // Direct wiper writes at both ends and mid range
  task automatic t_wiper;
    logic [7:0] v [3] = '{8'h00, 8'hFF, 8'h3C};
    for (int k = 0; k < 3; k++) begin
      frm(id, ins(`DPS_OP_WR_WCR, 2'b00, k == 2), v[k], 24, 99);
      chk(k == 2 ? tap1 : tap0, oh(v[k]));
      chk(i_mst.oe_seen, 1'b0);
    end
  endtask
  // Address misses, then a paused read
  task automatic t_miss;
    frm({id[7:1], ~id[0]}, ins(`DPS_OP_WR_WCR, 2'b00, 1'b1), 8'h77, 24, 99);
    chk(tap1, oh(8'h3C));
    frm({id[7:2], ~id[1:0]}, ins(`DPS_OP_RD_WCR, 2'b00, 1'b1), 8'h00, 24, 99);
    chk(i_mst.oe_seen, 1'b0);
    frm(id, ins(`DPS_OP_RD_WCR, 2'b00, 1'b1), 8'h00, 24, 5);
    chk(i_mst.rd, 8'h3C);
  endtask
  // Stored write: flag length, status reads, standby held off
  task automatic t_store;
    cnt = 0;
    fork
      for (int k = 0; k < 2000; k++) begin
        tick(1);
        if (wip === 1'b1) cnt++;
        else if (cnt > 0) break;
      end
      begin
        frm(id, ins(`DPS_OP_WR_DR, 2'b10, 1'b0), 8'h5A, 24, 99);
        frm(id, ins(`DPS_OP_RD_SR, 2'b00, 1'b0), 8'h00, 24, 99);
        chk(i_mst.rd, 8'h01);
        chk(stby, 1'b0);
      end
    join
    chk(cnt >= NV && cnt <= NV + 1, 1'b1);
    frm(id, ins(`DPS_OP_RD_SR, 2'b00, 1'b0), 8'h00, 24, 99);
    chk(i_mst.rd, 8'h00);
    chk(stby, 1'b1);
    frm(id, ins(`DPS_OP_RD_DR, 2'b10, 1'b0), 8'h00, 24, 99);
    chk(i_mst.rd, 8'h5A);
  endtask
  // Guard low refuses both kinds of stored write
  task automatic t_guard;
    @(posedge clk) guard_n <= 1'b0;
    tick(4);
    frm(id, ins(`DPS_OP_WR_DR, 2'b01, 1'b0), 8'h33, 24, 99);
    chk(wip, 1'b0);
    frm(id, ins(`DPS_OP_W2DR, 2'b01, 1'b0), 8'h00, 16, 99);
    chk(wip, 1'b0);
    @(posedge clk) guard_n <= 1'b1;
    tick(4);
    frm(id, ins(`DPS_OP_RD_DR, 2'b01, 1'b0), 8'h00, 24, 99);
    chk(i_mst.rd, 8'h80);
  endtask
  // Transfers, single and global
  task automatic t_xfer;
    frm(id, ins(`DPS_OP_DR2W, 2'b10, 1'b0), 8'h00, 16, 99);
    chk(tap0, oh(8'h5A));
    frm(id, ins(`DPS_OP_W2DR, 2'b11, 1'b1), 8'h00, 16, 99);
    chk(wip, 1'b1);
    wait_wip;
    frm(id, ins(`DPS_OP_RD_DR, 2'b11, 1'b1), 8'h00, 24, 99);
    chk(i_mst.rd, 8'h3C);
    frm(id, ins(`DPS_OP_G_DR2W, 2'b00, 1'b0), 8'h00, 16, 99);
    chk(tap0, oh(8'h80));
    chk(tap1, oh(8'h80));
    frm(id, ins(`DPS_OP_G_W2DR, 2'b11, 1'b0), 8'h00, 16, 99);
    wait_wip;
    frm(id, ins(`DPS_OP_RD_DR, 2'b11, 1'b1), 8'h00, 24, 99);
    chk(i_mst.rd, 8'h80);
  endtask
  // Stepping saturates at the top, then walks down
  task automatic t_step;
    frm(id, ins(`DPS_OP_WR_WCR, 2'b00, 1'b0), 8'hFE, 24, 99);
    frm(id, ins(`DPS_OP_STEP, 2'b00, 1'b0), 8'hC0, 21, 99);
    chk(tap0, oh(8'hFC));
  endtask
  // Main sequence
  initial begin
    t_boot;
    t_wiper;
    t_miss;
    t_store;
    t_guard;
    t_xfer;
    t_step;
    end_of_test;
  end
endmodule
`default_nettype wire
